// ===== design/mct_consts.svh
// Register offsets, field positions, reset values and flag indices of the commutation timer core
`ifndef MCT_CONSTS_SVH
`define MCT_CONSTS_SVH
// ============================================================
// Register byte offsets
`define MCT_OFF_COUNT 12'h000
`define MCT_OFF_COUNT_LOW 12'h004
`define MCT_OFF_ZPREV 12'h008
`define MCT_OFF_ZCUR 12'h00c
`define MCT_OFF_NCOMP 12'h010
`define MCT_OFF_DEMAG 12'h014
`define MCT_OFF_WEIGHT 12'h018
`define MCT_OFF_PRESC 12'h01c
`define MCT_OFF_CTRL 12'h020
`define MCT_OFF_ENABLE 12'h024
`define MCT_OFF_STATUS 12'h028
`define MCT_OFF_PWM_CFG 12'h02c
`define MCT_OFF_PERIOD 12'h030
`define MCT_OFF_PHASE_U 12'h034
`define MCT_OFF_PHASE_V 12'h038
`define MCT_OFF_PHASE_W 12'h03c
// ============================================================
// Control register bits
`define MCT_CTRL_GATE 0
`define MCT_CTRL_AUTO 1
`define MCT_CTRL_SEL 2
`define MCT_CTRL_SPEED 3
`define MCT_CTRL_SWCAP 4
// ============================================================
// Status and enable bit positions
`define MCT_FL_COMM 0
`define MCT_FL_DEMAG 1
`define MCT_FL_ZERO 2
`define MCT_FL_ESTOP 3
`define MCT_FL_CURRENT_LIMIT_ENABLE 4
`define MCT_FL_RDOWN 5
`define MCT_FL_RUP 6
`define MCT_FL_PWMUPD 7
`define MCT_FL_SPEED 8
`define MCT_FL_SAMPLE 9
// ============================================================
// Reset values and limits
`define MCT_RST_BYTE 8'h00
`define MCT_STEP_MAX 4'hf
`define MCT_STEP_MIN 4'h0
`endif

// ===== design/mct_pkg.sv
// Types shared by the commutation timer core
`default_nettype none
package mct_pkg;
  // Event strobes from the motor phase logic, one-cycle pulses
  typedef struct packed {
    logic zero_cross;
    logic demag_hw;
    logic estop;
    logic current_limit;
    logic sampling_out;
    logic ratio_up;
    logic ratio_down;
  } mct_evt_s;

  // Whole state of the core
  typedef struct packed {
    logic [7:0] cnt;
    logic [7:0] cnt_lo;
    logic [7:0] zprev;
    logic [7:0] zcur;
    logic [7:0] ncomp;
    logic [7:0] demag;
    logic [7:0] weight;
    logic [7:0] presc;
    logic [3:0] pre_div;
    logic [4:0] ctrl;
    logic [9:0] en;
    logic [9:0] fl;
    logic cap_blk;
    logic gate_q;
    logic [7:0] rep_pre;
    logic [7:0] pcfg_pre;
    logic [7:0] rep_cnt;
    logic [7:0] pcfg_act;
    logic [11:0] per_pre;
    logic [11:0] u_pre;
    logic [11:0] v_pre;
    logic [11:0] w_pre;
    logic [11:0] per_act;
    logic [11:0] u_act;
    logic [11:0] v_act;
    logic [11:0] w_act;
    logic [11:0] pcnt;
    logic [2:0] pwm;
    logic comm;
    logic [2:0] vec;
    logic wake;
  } mct_state_s;
endpackage
`default_nettype wire

// ===== design/mct_core.sv
// Commutation and speed-measurement timer core with APB register access
//
// Added by the designer: register access over APB and the placing of the registers.
`default_nettype none
`include "mct_consts.svh"

// What this block does
// - Gate clear holds PWM counter at zero
// - Setting gate starts PWM counter from zero
// - Gate set forces update event and flag
// - Wait mode runs on, interrupts wake
// - Halt freezes registers, no wake events
// - Interrupt needs enable and clear global mask
// - Events routed onto three shared vectors
// - Counter register readable and writable 8-bit
// - Count read captures pair in speed mode
// - Low byte extends counter to 16 bits in speed mode
// - Previous capture holds prior or low byte
// - Current capture holds latest or high byte
// - Current read blocks captures until previous read
// - Counter compared with next-commutation compare
// - Demag register compares or captures hardware demag
// - Speed mode demag match raises speed error
// - Auto mode loads compare from weighted capture
// - Prescale holds sampling and step fields
// - Step field follows ratio up/down events
// - PWM update flag set on transfer
module mct_core
  import mct_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire mct_evt_s evt,
  input wire logic global_irq_mask,
  input wire logic wait_mode,
  input wire logic halt_mode,
  output logic [2:0] irq_vec,
  output logic wake_req,
  output logic commutation_pulse,
  output logic [11:0] pwm_count,
  output logic [2:0] pwm_phase
);

  // ============================================================
  // Reset release
  logic [1:0] rst_sync_q; // Two-stage release of reset
  logic rst_n; // Synchronised reset

  // Assert at once, release after two edges to avoid metastable release
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_sync_q <= 2'b00;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // ============================================================
  // Bus decode
  mct_state_s s_q; // Registered state
  mct_state_s s_d; // Next state
  logic acc; // Access phase
  logic wr; // Write in access phase
  logic rd; // Read in access phase
  logic hit; // Mapped address
  logic [31:0] rdata; // Read mux

  assign acc = psel & penable;
  assign wr = acc & pwrite;
  assign rd = acc & ~pwrite;
  // Every register answers in its access cycle, so no wait logic is needed
  assign pready = 1'b1; // Zero wait states
  assign pslverr = acc & ~hit; // Unmapped address answers error

  // Read mux over the register map, narrow data in low bits
  always_comb begin
    hit = 1'b1;
    rdata = 32'h0000_0000;
    if (paddr == `MCT_OFF_COUNT) begin
      rdata[7:0] = s_q.cnt;
    end else if (paddr == `MCT_OFF_COUNT_LOW) begin
      rdata[7:0] = s_q.cnt_lo;
    end else if (paddr == `MCT_OFF_ZPREV) begin
      rdata[7:0] = s_q.zprev;
    end else if (paddr == `MCT_OFF_ZCUR) begin
      rdata[7:0] = s_q.zcur;
    end else if (paddr == `MCT_OFF_NCOMP) begin
      rdata[7:0] = s_q.ncomp;
    end else if (paddr == `MCT_OFF_DEMAG) begin
      rdata[7:0] = s_q.demag;
    end else if (paddr == `MCT_OFF_WEIGHT) begin
      rdata[7:0] = s_q.weight;
    end else if (paddr == `MCT_OFF_PRESC) begin
      rdata[7:0] = s_q.presc;
    end else if (paddr == `MCT_OFF_CTRL) begin
      rdata[4:0] = s_q.ctrl;
    end else if (paddr == `MCT_OFF_ENABLE) begin
      rdata[9:0] = s_q.en;
    end else if (paddr == `MCT_OFF_STATUS) begin
      rdata[9:0] = s_q.fl;
    end else if (paddr == `MCT_OFF_PWM_CFG) begin
      rdata[15:0] = {s_q.pcfg_pre, s_q.rep_pre}; // Reads show preload copies
    end else if (paddr == `MCT_OFF_PERIOD) begin
      rdata[11:0] = s_q.per_pre;
    end else if (paddr == `MCT_OFF_PHASE_U) begin
      rdata[11:0] = s_q.u_pre;
    end else if (paddr == `MCT_OFF_PHASE_V) begin
      rdata[11:0] = s_q.v_pre;
    end else if (paddr == `MCT_OFF_PHASE_W) begin
      rdata[11:0] = s_q.w_pre;
    end else begin
      hit = 1'b0;
    end
  end
  assign prdata = rdata;

  // ============================================================
  // Next-state logic
  logic run; // Gate set and not halted
  logic speed; // Speed sensor mode
  logic tick; // Prescaled timer step
  logic [3:0] step; // Step ratio field
  logic [7:0] cap_src; // Capture chosen for the multiplier
  logic [15:0] prod; // Capture times weight
  logic upd; // PWM transfer event
  logic [9:0] set; // Hardware flag sets
  logic [9:0] en_x; // Enables, ratio enable shared
  logic [9:0] pend; // Enabled pending events

  // One process builds the whole next state from the current one
  always_comb begin
    s_d = s_q;
    set = 10'h000;
    upd = 1'b0;
    speed = s_q.ctrl[`MCT_CTRL_SPEED];
    step = s_q.presc[3:0];
    run = s_q.ctrl[`MCT_CTRL_GATE] & ~halt_mode;
    tick = run && (s_q.pre_div >= step);
    cap_src = 8'h00;
    prod = 16'h0000;
    s_d.comm = 1'b0;

    // Prescaler divides the timer clock by step plus one
    if (run) begin
      s_d.pre_div = tick ? 4'h0 : s_q.pre_div + 4'h1;
    end

    // Counter advances on each prescaled tick
    if (tick) begin
      if (speed) begin
        {s_d.cnt, s_d.cnt_lo} = {s_q.cnt, s_q.cnt_lo} + 16'h0001;
      end else if (s_q.cnt == s_q.ncomp) begin
        s_d.cnt = `MCT_RST_BYTE;
        s_d.comm = 1'b1;
        set[`MCT_FL_COMM] = 1'b1;
      end else begin
        s_d.cnt = s_q.cnt + 8'h01;
      end
    end

    // Demag register: simulated compare or speed error compare
    if (run && s_q.cnt == s_q.demag) begin
      if (speed) begin
        set[`MCT_FL_SPEED] = 1'b1;
      end else if (tick) begin
        set[`MCT_FL_DEMAG] = 1'b1;
      end
    end

    // Hardware events seen only while the peripheral clock runs
    if (run) begin
      if (evt.demag_hw && !speed) begin
        s_d.demag = s_q.cnt;
        set[`MCT_FL_DEMAG] = 1'b1;
      end
      if (evt.zero_cross) begin
        set[`MCT_FL_ZERO] = 1'b1;
        if (speed) begin
          if (!s_q.cap_blk && !s_q.ctrl[`MCT_CTRL_SWCAP]) begin
            s_d.zcur = s_q.cnt;
            s_d.zprev = s_q.cnt_lo;
            set[`MCT_FL_COMM] = 1'b1;
          end
        end else begin
          s_d.zprev = s_q.zcur;
          s_d.zcur = s_q.cnt;
          if (s_q.ctrl[`MCT_CTRL_AUTO]) begin
            // New current capture is the count just taken
            cap_src = s_q.ctrl[`MCT_CTRL_SEL] ? s_q.zcur : s_q.cnt;
            prod = cap_src * s_q.weight;
            s_d.ncomp = prod[15:8];
          end
        end
      end
      set[`MCT_FL_ESTOP] = evt.estop;
      set[`MCT_FL_CURRENT_LIMIT_ENABLE] = evt.current_limit;
      set[`MCT_FL_SAMPLE] = evt.sampling_out;
      set[`MCT_FL_RUP] = evt.ratio_up;
      set[`MCT_FL_RDOWN] = evt.ratio_down;
      // Step field saturates at both ends rather than wrapping
      // Wrapping would turn one ratio step into a huge speed jump
      if (evt.ratio_up && !evt.ratio_down && step != `MCT_STEP_MAX) begin
        s_d.presc[3:0] = step + 4'h1;
      end else if (evt.ratio_down && !evt.ratio_up && step != `MCT_STEP_MIN) begin
        s_d.presc[3:0] = step - 4'h1;
      end
    end

    // PWM generator: stopped at zero while the gate is clear
    s_d.gate_q = s_q.ctrl[`MCT_CTRL_GATE];
    if (!s_q.ctrl[`MCT_CTRL_GATE]) begin
      s_d.pcnt = 12'h000;
    end else if (!s_q.gate_q) begin
      upd = 1'b1;
      s_d.pcnt = 12'h000;
    end else if (!halt_mode) begin
      if (s_q.pcnt >= s_q.per_act) begin
        s_d.pcnt = 12'h000;
        if (s_q.rep_cnt == 8'h00) begin
          upd = 1'b1;
        end else begin
          s_d.rep_cnt = s_q.rep_cnt - 8'h01;
        end
      end else begin
        s_d.pcnt = s_q.pcnt + 12'h001;
      end
    end
    // Preload to active transfer
    // All active copies move together so phases never mix two periods
    if (upd) begin
      s_d.rep_cnt = s_q.rep_pre;
      s_d.pcfg_act = s_q.pcfg_pre;
      s_d.per_act = s_q.per_pre;
      s_d.u_act = s_q.u_pre;
      s_d.v_act = s_q.v_pre;
      s_d.w_act = s_q.w_pre;
      set[`MCT_FL_PWMUPD] = 1'b1;
    end
    // Phase outputs high until the counter reaches the compare
    s_d.pwm = {s_q.pcnt < s_q.w_act, s_q.pcnt < s_q.v_act, s_q.pcnt < s_q.u_act};

    // Register writes, also while the gate is clear
    if (wr && !halt_mode) begin
      if (paddr == `MCT_OFF_COUNT) begin
        s_d.cnt = pwdata[7:0];
      end else if (paddr == `MCT_OFF_COUNT_LOW) begin
        s_d.cnt_lo = pwdata[7:0];
      end else if (paddr == `MCT_OFF_ZPREV) begin
        s_d.zprev = pwdata[7:0];
      end else if (paddr == `MCT_OFF_ZCUR) begin
        s_d.zcur = pwdata[7:0];
      end else if (paddr == `MCT_OFF_NCOMP) begin
        s_d.ncomp = pwdata[7:0];
      end else if (paddr == `MCT_OFF_DEMAG) begin
        s_d.demag = pwdata[7:0];
      end else if (paddr == `MCT_OFF_WEIGHT) begin
        s_d.weight = pwdata[7:0];
      end else if (paddr == `MCT_OFF_PRESC) begin
        s_d.presc = pwdata[7:0];
      end else if (paddr == `MCT_OFF_CTRL) begin
        s_d.ctrl = pwdata[4:0];
      end else if (paddr == `MCT_OFF_ENABLE) begin
        s_d.en = pwdata[9:0];
      end else if (paddr == `MCT_OFF_STATUS) begin
        s_d.fl = s_q.fl & pwdata[9:0]; // Write zero clears a flag
      end else if (paddr == `MCT_OFF_PWM_CFG) begin
        {s_d.pcfg_pre, s_d.rep_pre} = pwdata[15:0];
      end else if (paddr == `MCT_OFF_PERIOD) begin
        s_d.per_pre = pwdata[11:0];
      end else if (paddr == `MCT_OFF_PHASE_U) begin
        s_d.u_pre = pwdata[11:0];
      end else if (paddr == `MCT_OFF_PHASE_V) begin
        s_d.v_pre = pwdata[11:0];
      end else if (paddr == `MCT_OFF_PHASE_W) begin
        s_d.w_pre = pwdata[11:0];
      end
    end

    // Read side effects of the speed capture path
    if (rd && speed) begin
      if (paddr == `MCT_OFF_COUNT && s_q.ctrl[`MCT_CTRL_SWCAP] && !s_q.cap_blk) begin
        s_d.zcur = s_q.cnt;
        s_d.zprev = s_q.cnt_lo;
      end else if (paddr == `MCT_OFF_ZCUR) begin
        s_d.cap_blk = 1'b1;
      end else if (paddr == `MCT_OFF_ZPREV) begin
        s_d.cap_blk = 1'b0;
      end
    end

    // Hardware set wins over a clearing write in the same cycle
    // Otherwise an event landing on a clear would be lost silently
    s_d.fl = s_d.fl | set;

    // Shared ratio enable covers both ratio flags
    // The spare enable bit is kept for software but gates nothing
    en_x = s_q.en;
    en_x[`MCT_FL_RUP] = s_q.en[`MCT_FL_RDOWN];
    pend = global_irq_mask ? 10'h000 : (s_q.fl & en_x);
    // Three vectors: safety, position timing, PWM, ratio and sampling
    s_d.vec[0] = pend[`MCT_FL_ESTOP] | pend[`MCT_FL_CURRENT_LIMIT_ENABLE];
    s_d.vec[1] = pend[`MCT_FL_COMM] | pend[`MCT_FL_DEMAG] | pend[`MCT_FL_ZERO] | pend[`MCT_FL_SPEED];
    s_d.vec[2] = pend[`MCT_FL_PWMUPD] | pend[`MCT_FL_RUP] | pend[`MCT_FL_RDOWN] | pend[`MCT_FL_SAMPLE];
    s_d.wake = wait_mode & (|pend);

    // Halt freezes everything and raises nothing
    // Freezing the whole state keeps preloads and flags coherent for resume
    if (halt_mode) begin
      s_d = s_q;
      s_d.vec = 3'b000;
      s_d.wake = 1'b0;
      s_d.comm = 1'b0;
    end
  end

  // ============================================================
  // State register
  // Single register for all state, cleared by the released reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // ============================================================
  // Outputs, all from flip-flops
  assign irq_vec = s_q.vec;
  assign wake_req = s_q.wake;
  assign commutation_pulse = s_q.comm;
  assign pwm_count = s_q.pcnt;
  assign pwm_phase = s_q.pwm;

endmodule // mct_core
`default_nettype wire

// ===== dv/mct_monitor.sv
// Port-level assertion checker for the commutation timer core
`default_nettype none
module mct_monitor
  import mct_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire mct_evt_s evt,
  input wire logic global_irq_mask,
  input wire logic wait_mode,
  input wire logic halt_mode,
  input wire logic [2:0] irq_vec,
  input wire logic wake_req,
  input wire logic commutation_pulse,
  input wire logic [11:0] pwm_count,
  input wire logic [2:0] pwm_phase
);
  timeunit 1ns;
  timeprecision 1ps;
  // ====
  // Shadow of gate bit and enable word, as software wrote them
  logic gate_q;
  logic [9:0] en_q;
  logic wr_ok;
  // Halt blocks writes, so the shadow must ignore them too
  assign wr_ok = psel && penable && pwrite && !halt_mode;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      gate_q <= 1'b0;
      en_q <= 10'h000;
    end else begin
      if (wr_ok && paddr == 12'h020) begin
        gate_q <= pwdata[0];
      end
      if (wr_ok && paddr == 12'h024) begin
        en_q <= pwdata[9:0];
      end
    end
  end
  // ====
  // Properties, all on the one clock
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  chk_pwm_held: assert property ((!gate_q) [*3] |-> pwm_count == 12'h000)
    else $error("pwm counter moves with gate clear");
  chk_gate_start: assert property ($rose(gate_q) |-> ##[0:2] pwm_count == 12'h000)
    else $error("pwm counter not restarted at zero");
  chk_upd_irq: assert property ($rose(gate_q) && en_q[7] && !global_irq_mask |-> ##[1:4] irq_vec[2])
    else $error("no update interrupt after gate set");
  chk_mask_quiet: assert property (global_irq_mask |=> irq_vec == 3'b000)
    else $error("interrupt while globally masked");
  chk_fault_vec: assert property (irq_vec[0] |-> $past(en_q[3] || en_q[4]))
    else $error("fault vector without its enable");
  chk_slow_vec: assert property (irq_vec[2] |-> $past(en_q[5] || en_q[7] || en_q[9]))
    else $error("third vector from a foreign source");
  chk_wake_wait: assert property (wake_req |-> $past(wait_mode) && $past(en_q != 10'h000))
    else $error("wake outside wait or with nothing enabled");
  chk_halt_freeze: assert property (halt_mode |=> $stable(pwm_count))
    else $error("pwm counter moves in halt");
endmodule // mct_monitor
bind mct_core mct_monitor i_mon (.clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .evt(evt), .global_irq_mask(global_irq_mask), .wait_mode(wait_mode), .halt_mode(halt_mode),
  .irq_vec(irq_vec), .wake_req(wake_req), .commutation_pulse(commutation_pulse), .pwm_count(pwm_count),
  .pwm_phase(pwm_phase));
`default_nettype wire

// ===== dv/mct_phase_model.sv
// Behavioural strobe source standing in for the motor phase logic
`default_nettype none
module mct_phase_model
  import mct_pkg::*;
(
  input wire logic clk,
  input wire logic fire,
  input wire logic [2:0] kind,
  input wire logic [3:0] lag,
  output var mct_evt_s evt
);
  timeunit 1ns;
  timeprecision 1ps;
  // ====
  // One-clock strobe after a chosen lag; kind 0 is the msb
  initial begin
    evt = '0;
    forever begin
      @(posedge clk);
      if (fire) begin
        repeat (lag) @(posedge clk);
        evt <= mct_evt_s'(7'h40 >> kind);
        @(posedge clk);
        evt <= '0;
      end
    end
  end
endmodule // mct_phase_model
`default_nettype wire

// ===== dv/tb.sv
// Self-checking bench for the commutation timer core
`default_nettype none
module tb
  import mct_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ====
  // Bench signals
  logic clk, reset_n, psel, penable, pwrite, gmask, wt, ht, fire, err;
  logic pready, pslverr, wake_req, comm_p;
  logic [11:0] paddr, pwm_count, p;
  logic [31:0] pwdata, prdata, rdat;
  logic [2:0] irq_vec, pwm_phase, kind;
  logic [3:0] lag, st;
  logic [7:0] v[8];
  logic [7:0] z, w, c;
  mct_evt_s evt;
  int mismatches, cmp_count, i, n, b;
  int fb[7] = '{2, 1, 3, 4, 9, 6, 5}; // Status bit of each strobe
  mct_core i_dut (.clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .evt(evt),
    .global_irq_mask(gmask), .wait_mode(wt), .halt_mode(ht), .irq_vec(irq_vec), .wake_req(wake_req),
    .commutation_pulse(comm_p), .pwm_count(pwm_count), .pwm_phase(pwm_phase));
  mct_phase_model i_phase (.clk(clk), .fire(fire), .kind(kind), .lag(lag), .evt(evt));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // ====
  // Helpers
  function automatic logic [2:0] vec_of(input int f);
    return (f == 3 || f == 4) ? 3'b001 : (f <= 2 || f == 8) ? 3'b010 : 3'b100;
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %0t seen %h want %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // A spent bound counts as a miss and ends the run
  task automatic limit(input int bound);
    if (n >= bound) begin
      mismatches++;
      give_verdict();
    end
  endtask
  // Setup, access until pready, then one idle edge so drives never collide
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) limit(20);
    rdat = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, '0);
    check(rdat, exp);
  endtask
  // Random lag so the strobe arrives both promptly and late
  task automatic fire_evt(input int k);
    fire <= 1'b1;
    kind <= 3'(k);
    lag <= 4'($urandom % 4);
    @(posedge clk);
    fire <= 1'b0;
    repeat (8) @(posedge clk);
  endtask
  task automatic wait_pulse();
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (comm_p !== 1'b1 && n < 9000);
    if (comm_p !== 1'b1) limit(9000);
  endtask
  // ====
  // Main sequence
  initial begin
    {reset_n, psel, penable, pwrite, gmask, wt, ht, fire} = '0;
    paddr = '0;
    pwdata = '0;
    kind = '0;
    lag = '0;
    mismatches = 0;
    cmp_count = 0;
    void'($urandom(41345));
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk);
    for (i = 0; i < 8; i++) begin
      rd_chk(12'(4 * i), 32'h0);
    end
    apb(1'b0, 12'h100, '0);
    check(err, 1'b1);
    // Gate clear: writes still land, pwm counter idle
    for (i = 0; i < 8; i++) begin
      v[i] = 8'($urandom);
      apb(1'b1, 12'(4 * i), {24'h0, v[i]});
    end
    for (i = 0; i < 8; i++) begin
      rd_chk(12'(4 * i), {24'h0, v[i]});
    end
    check(pwm_count, 12'h000);
    // Gate set: update event, then edge-aligned count 0..10
    apb(1'b1, 12'h030, 32'd10);
    apb(1'b1, 12'h034, 32'd4);
    apb(1'b1, 12'h038, 32'd7);
    apb(1'b1, 12'h02c, '0);
    apb(1'b1, 12'h024, 32'h080);
    apb(1'b1, 12'h020, 32'h1);
    // Flag lands one edge after the gate, the vector one edge later
    repeat (2) @(posedge clk);
    check(irq_vec, 3'b100);
    apb(1'b0, 12'h028, '0);
    check(rdat[7], 1'b1);
    p = pwm_count;
    for (i = 0; i < 30; i++) begin
      @(posedge clk);
      check(pwm_count, (p == 12'd10) ? 12'd0 : p + 12'd1);
      check(pwm_phase, {1'b0, p < 12'd7, p < 12'd4});
      p = pwm_count;
    end
    // Each strobe alone except hardware demag: flag, vector, step field from the top corner
    st = 4'hf;
    apb(1'b1, 12'h01c, {24'h0, v[7][7:4], st});
    for (i = 0; i < 7; i++) begin
      if (i == 1) continue;
      b = (fb[i] == 6) ? 5 : fb[i];
      apb(1'b1, 12'h024, 32'(1 << b));
      apb(1'b1, 12'h028, '0);
      fire_evt(i);
      apb(1'b0, 12'h028, '0);
      check(rdat[fb[i]], 1'b1);
      check(irq_vec, vec_of(fb[i]));
      if (i == 5) st = (st == 4'hf) ? st : st + 4'h1;
      if (i == 6) st = (st == 4'h0) ? st : st - 4'h1;
      apb(1'b0, 12'h01c, '0);
      check(rdat[7:0], {v[7][7:4], st});
    end
    gmask <= 1'b1;
    repeat (3) @(posedge clk);
    check(irq_vec, 3'b000);
    gmask <= 1'b0;
    repeat (3) @(posedge clk);
    check(irq_vec, 3'b100);
    // Interval between commutations
    z = 8'(3 + $urandom % 5);
    apb(1'b1, 12'h010, {24'h0, z});
    wait_pulse();
    wait_pulse();
    check(n, (z + 1) * (st + 1));
    // Motor stopped first, then wait and halt
    apb(1'b1, 12'h020, '0);
    wt <= 1'b1;
    repeat (3) @(posedge clk);
    check(wake_req, 1'b1);
    // Wait level kept high so only halt can silence the wake
    ht <= 1'b1;
    apb(1'b1, 12'h018, {24'h0, ~v[6]});
    check(wake_req, 1'b0);
    ht <= 1'b0;
    wt <= 1'b0;
    rd_chk(12'h018, {24'h0, v[6]});
    // Auto mode with the older capture selected
    z = 8'($urandom);
    w = 8'($urandom);
    apb(1'b1, 12'h00c, {24'h0, z});
    apb(1'b1, 12'h018, {24'h0, w});
    apb(1'b1, 12'h020, 32'h7);
    fire_evt(0);
    rd_chk(12'h010, 32'((16'(z) * 16'(w)) >> 8));
    rd_chk(12'h008, {24'h0, z});
    // Speed mode: read capture, blocking, release
    apb(1'b1, 12'h020, 32'h19);
    apb(1'b1, 12'h01c, '0);
    apb(1'b1, 12'h004, '0);
    apb(1'b1, 12'h000, 32'h12);
    apb(1'b0, 12'h000, '0);
    c = rdat[7:0];
    rd_chk(12'h00c, {24'h0, c});
    apb(1'b1, 12'h020, 32'h09);
    fire_evt(0);
    rd_chk(12'h00c, {24'h0, c});
    apb(1'b1, 12'h000, 32'h40);
    apb(1'b0, 12'h008, '0);
    fire_evt(0);
    rd_chk(12'h00c, 32'h40);
    // Demag value equal to the running high byte flags a speed error
    apb(1'b1, 12'h014, 32'h40);
    apb(1'b0, 12'h028, '0);
    check(rdat[8], 1'b1);
    // Low byte at its top carries into the high byte
    apb(1'b1, 12'h004, 32'hff);
    rd_chk(12'h000, 32'h41);
    give_verdict();
  end
endmodule // tb
`default_nettype wire
